// [logic/sld_dc_engine.sv]
/*
  DC test engine: runs one channel's checks.
  Assumes the front end answers every request once.
*/
module sld_dc_engine (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     clk_en,
  sld_dc_if.eng                         dc,
  input  wire logic                     meas_done,
  input  wire logic                     meas_flag,
  input  wire logic [sld_pkg::MEAS_W-1:0] meas_value,
  output logic                          meas_req,
  output sld_pkg::sld_test_t            meas_kind,
  output logic [1:0]                    meas_chan
);
  import sld_pkg::*;

  sld_eng_t          st_q, st_d;
  sld_test_t         test_q, test_d;
  logic [1:0]        chan_q, chan_d;
  logic [THR_W-1:0]  thr_q, thr_d;
  logic              line_q, line_d;
  logic [RES_W-1:0]  res_q, res_d;
  logic              req_q, req_d;
  logic              done_q, done_d;

  always_comb begin
    st_d   = st_q;
    test_d = test_q;
    chan_d = chan_q;
    thr_d  = thr_q;
    line_d = line_q;
    res_d  = res_q;
    req_d  = 1'b0;
    done_d = 1'b0;
    unique case (st_q)
      EN_IDLE: begin
        if (dc.start) begin
          chan_d = dc.chan;
          thr_d  = dc.thr;
          line_d = dc.line_en;
          res_d  = '0;
          test_d = T_S2P;
          st_d   = EN_REQ;
        end
      end
      EN_REQ: begin
        req_d = 1'b1;
        st_d  = EN_WAIT;
      end
      EN_WAIT: begin
        if (meas_done) begin
          if (test_q == T_SL) begin
            res_d[RES_SL] = meas_value < {8'h00, thr_q};  // [R8]
          end else begin
            res_d[int'(test_q)] = meas_flag;  // [R7]
          end
          st_d = EN_REQ;
          unique case (test_q)
            T_S2P: test_d = T_S2G;
            T_S2G: test_d = T_OL;
            T_OL:  test_d = T_SL;
            T_SL: begin
              if (res_d[RES_OL] && line_q) begin
                test_d = T_LINE;  // [R9]
              end else begin
                st_d = EN_DONE;
              end
            end
            T_LINE: st_d = EN_DONE;
          endcase
        end
      end
      EN_DONE: begin
        done_d = 1'b1;
        st_d   = EN_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= EN_IDLE;
      test_q <= T_S2P;
      {chan_q, thr_q, line_q, res_q, req_q, done_q} <= '0;
    end else if (clk_en) begin
      st_q   <= st_d;
      test_q <= test_d;
      chan_q <= chan_d;
      thr_q  <= thr_d;
      line_q <= line_d;
      res_q  <= res_d;
      req_q  <= req_d;
      done_q <= done_d;
    end
  end

  assign dc.done   = done_q;
  assign dc.result = res_q;
  assign meas_req  = req_q;
  assign meas_kind = test_q;
  assign meas_chan = chan_q;

endmodule : sld_dc_engine

// [logic/sld_dc_if.sv]
/*
  Sequencer to DC engine handshake.
  Assumes one shared pclk.
*/
interface sld_dc_if;
  import sld_pkg::*;
  logic                    start;
  logic [1:0]              chan;
  logic [THR_W-1:0]        thr;
  logic                    line_en;
  logic                    done;
  logic [RES_W-1:0]        result;

  modport ctrl (output start, chan, thr, line_en, input done, result);
  modport eng  (input start, chan, thr, line_en, output done, result);
endinterface : sld_dc_if

// [logic/sld_diag_top.sv]
/*
  Load diagnostics with APB registers, DC and AC
  test sequencing.
  Assumes a front end that answers each request and
  a power stage that follows chan_state.
*/
module sld_diag_top (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             clk_en,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [sld_pkg::ADDR_W-1:0]       paddr,
  input  wire logic [sld_pkg::DATA_W-1:0]       pwdata,
  output logic      [sld_pkg::DATA_W-1:0]       prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic                             supply_ok,
  output logic                                  meas_req,
  output sld_pkg::sld_test_t                    meas_kind,
  output logic      [1:0]                       meas_chan,
  input  wire logic                             meas_done,
  input  wire logic                             meas_flag,
  input  wire logic [sld_pkg::MEAS_W-1:0]       meas_value,
  output logic                                  ac_req,
  output logic      [1:0]                       ac_chan,
  output logic                                  ac_loopback_select,
  input  wire logic                             ac_done,
  input  wire logic [sld_pkg::MEAS_W-1:0]       ac_value,
  output logic      [sld_pkg::GAIN_W-1:0]       tone_gain,
  output logic      [3*sld_pkg::CHANNELS-1:0]   chan_state,
  output logic                                  pair12_parallel_select,
  output logic                                  pair34_parallel_select
);
  import sld_pkg::*;

  sld_dc_if dcif ();

  // Bus handshake state
  logic               pready_q, pready_d;
  logic               pslverr_q, pslverr_d;
  logic [DATA_W-1:0]  prdata_q, prdata_d;
  logic [DATA_W-1:0]  rd_data;
  logic               rd_hit;
  logic [7:0]         idx;
  logic               acc, wr_en;

  // Control and status state
  logic [1:0]                         pair_q, pair_d;
  logic                               bypass_q, bypass_d;
  logic                               line_en_q, line_en_d;
  logic                               loop_q, loop_d;
  logic [CHANNELS-1:0][1:0]           cmd_q, cmd_d;
  logic [CHANNELS-1:0][2:0]           chan_q, chan_d;
  logic [CHANNELS-1:0][THR_W-1:0]     thr_q, thr_d;
  logic [CHANNELS-1:0][RES_W-1:0]     res_q, res_d;
  logic [CHANNELS-1:0][MEAS_W-1:0]    imp_q, imp_d;
  logic [1:0][MEAS_W-1:0]             ph_q, ph_d;
  logic [CHANNELS-1:0]                dc_pend_q, dc_pend_d;
  logic [CHANNELS-1:0]                ac_pend_q, ac_pend_d;
  sld_seq_t                           seq_q, seq_d;
  logic [1:0]                         cur_q, cur_d;
  logic [CNT_W-1:0]                   cnt_q, cnt_d;
  logic [GAIN_W-1:0]                  gain_q, gain_d;
  logic                               dc_start_q, dc_start_d;
  logic                               ac_req_q, ac_req_d;

  assign idx   = paddr[ADDR_W-1:2];
  assign acc   = psel & penable & ~pready_q;
  assign wr_en = psel & penable & pready_q & pwrite;

  // Read mux
  always_comb begin
    rd_data = '0;
    rd_hit  = 1'b1;
    if (idx == IDX_PAIR) begin
      rd_data[PAIR12_BIT] = pair_q[1];
      rd_data[PAIR34_BIT] = pair_q[0];
    end else if (idx == IDX_CHAN_CMD) begin
      for (int c = 0; c < CHANNELS; c++) begin
        rd_data[2*c +: 2] = cmd_q[c];
      end
    end else if (idx == IDX_DC_CTRL) begin
      rd_data[DC_BYPASS_BIT] = bypass_q;
      rd_data[LINE_DET_BIT]  = line_en_q;
      rd_data[DC_MAN_LSB +: CHANNELS] = dc_pend_q;
    end else if (idx == IDX_SL_THR) begin
      rd_data = thr_q;
    end else if (idx == IDX_DC_STAT) begin
      for (int c = 0; c < CHANNELS; c++) begin
        rd_data[8*c +: RES_W] = res_q[c];  // [R6]
      end
    end else if (idx == IDX_CHAN_STAT) begin
      rd_data[3*CHANNELS-1:0] = chan_q;  // [R16]
      rd_data[SUPPLY_OK_BIT]  = supply_ok;
    end else if (idx == IDX_AC_EN) begin
      for (int c = 0; c < CHANNELS; c++) begin
        rd_data[ac_bit(c)] = ac_pend_q[c] | (chan_q[c] == CH_AC);
      end
    end else if (idx == IDX_AC_CFG) begin
      rd_data[LOOPBACK_BIT] = loop_q;
    end else if (idx >= IDX_AC_IMP0 && idx <= IDX_AC_IMP3) begin
      rd_data[MEAS_W-1:0] = imp_q[2'(idx - IDX_AC_IMP0)];  // [R15]
    end else if (idx == IDX_AC_PH0) begin
      rd_data[MEAS_W-1:0] = ph_q[0];  // [R19]
    end else if (idx == IDX_AC_PH1) begin
      rd_data[MEAS_W-1:0] = ph_q[1];  // [R19]
    end else begin
      rd_hit = 1'b0;
    end
  end

  // One wait state
  always_comb begin
    pready_d  = acc;
    pslverr_d = acc & ~rd_hit;
    prdata_d  = prdata_q;
    if (acc && !pwrite) begin
      prdata_d = rd_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else if (clk_en) begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // Sequencer and registers
  always_comb begin
    pair_d     = pair_q;
    bypass_d   = bypass_q;
    line_en_d  = line_en_q;
    loop_d     = loop_q;
    cmd_d      = cmd_q;
    chan_d     = chan_q;
    thr_d      = thr_q;
    res_d      = res_q;
    imp_d      = imp_q;
    ph_d       = ph_q;
    dc_pend_d  = dc_pend_q;
    ac_pend_d  = ac_pend_q;
    seq_d      = seq_q;
    cur_d      = cur_q;
    cnt_d      = cnt_q;
    gain_d     = gain_q;
    dc_start_d = 1'b0;
    ac_req_d   = 1'b0;

    unique case (seq_q)
      SQ_IDLE: begin
        if (supply_ok && dc_pend_q != '0) begin  // [R5]
          cur_d = lowest_ch(dc_pend_q);
          dc_pend_d[cur_d] = 1'b0;
          if (chan_q[cur_d] == CH_PLAY) begin
            chan_d[cur_d] = CH_RAMP;  // [R4]
            cnt_d = AUDIO_RAMP_CYC;
            seq_d = SQ_RAMP;
          end else begin
            chan_d[cur_d] = CH_DC;
            dc_start_d = 1'b1;
            seq_d = SQ_DC;
          end
        end else if (ac_pend_q != '0) begin
          cur_d = lowest_ch(ac_pend_q);
          ac_pend_d[cur_d] = 1'b0;
          chan_d[cur_d] = CH_AC;
          gain_d = '0;
          cnt_d = TONE_STEP_CYC;
          seq_d = SQ_AC_UP;
        end
      end
      SQ_RAMP: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else begin
          chan_d[cur_q] = CH_DC;  // [R4]
          dc_start_d = 1'b1;
          seq_d = SQ_DC;
        end
      end
      SQ_DC: begin
        if (dcif.done) begin
          res_d[cur_q] = dcif.result;  // [R6]
          if (dcif.result[RES_SL:RES_S2P] != '0) begin
            chan_d[cur_q] = CH_HIZ;
          end else begin
            chan_d[cur_q] = cmd_state(cmd_q[cur_q]);
          end
          seq_d = SQ_IDLE;
        end
      end
      SQ_AC_UP: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (gain_q == GAIN_MAX) begin
          ac_req_d = 1'b1;
          seq_d = SQ_AC_MEAS;
        end else begin
          gain_d = gain_q + 1'b1;  // [R13]
          cnt_d = TONE_STEP_CYC;
        end
      end
      SQ_AC_MEAS: begin
        if (ac_done) begin
          if (loop_q) begin
            ph_d[cur_q[1]] = ac_value;  // [R17] [R19]
          end else begin
            imp_d[cur_q] = ac_value;  // [R14] [R15]
          end
          cnt_d = TONE_STEP_CYC;
          seq_d = SQ_AC_DOWN;
        end
      end
      SQ_AC_DOWN: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (gain_q == '0) begin
          chan_d[cur_q] = CH_HIZ;  // [R16]
          seq_d = SQ_IDLE;
        end else begin
          gain_d = gain_q - 1'b1;  // [R13]
          cnt_d = TONE_STEP_CYC;
        end
      end
    endcase

    // Writes last: a set beats a same-cycle clear
    if (wr_en) begin
      if (idx == IDX_PAIR) begin
        pair_d = {pwdata[PAIR12_BIT], pwdata[PAIR34_BIT]};
      end else if (idx == IDX_CHAN_CMD) begin
        for (int c = 0; c < CHANNELS; c++) begin
          cmd_d[c] = pwdata[2*c +: 2];
          if (chan_d[c] == chan_q[c]) begin
            if (chan_q[c] == CH_HIZ
                && cmd_state(pwdata[2*c +: 2]) != CH_HIZ) begin
              if (bypass_q) begin
                chan_d[c] = cmd_state(pwdata[2*c +: 2]);  // [R1]
              end else begin
                dc_pend_d[c] = 1'b1;  // [R2]
              end
            end else if (chan_q[c] == CH_MUTE || chan_q[c] == CH_PLAY) begin
              chan_d[c] = cmd_state(pwdata[2*c +: 2]);
            end
          end
        end
      end else if (idx == IDX_DC_CTRL) begin
        bypass_d  = pwdata[DC_BYPASS_BIT];  // [R1]
        line_en_d = pwdata[LINE_DET_BIT];  // [R9]
        dc_pend_d = dc_pend_d | pwdata[DC_MAN_LSB +: CHANNELS];  // [R3]
      end else if (idx == IDX_SL_THR) begin
        thr_d = pwdata;  // [R8]
      end else if (idx == IDX_AC_EN) begin
        for (int c = 0; c < CHANNELS; c++) begin
          if (pwdata[ac_bit(c)] && chan_q[c] == CH_HIZ  // [R21]
              && (!loop_q || c == 0 || c == 2)) begin  // [R18]
            ac_pend_d[c] = 1'b1;  // [R14]
          end
        end
      end else if (idx == IDX_AC_CFG) begin
        loop_d = pwdata[LOOPBACK_BIT];  // [R17]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair_q     <= '0;
      bypass_q   <= 1'b0;
      line_en_q  <= 1'b0;
      loop_q     <= 1'b0;
      cmd_q      <= {CHANNELS{CMD_RST}};
      chan_q     <= {CHANNELS{CH_HIZ}};
      thr_q      <= {CHANNELS{SL_THR_RST}};
      res_q      <= '0;
      imp_q      <= '0;
      ph_q       <= '0;
      dc_pend_q  <= '0;
      ac_pend_q  <= '0;
      seq_q      <= SQ_IDLE;
      cur_q      <= 2'h0;
      cnt_q      <= '0;
      gain_q     <= '0;
      dc_start_q <= 1'b0;
      ac_req_q   <= 1'b0;
    end else if (clk_en) begin
      pair_q     <= pair_d;
      bypass_q   <= bypass_d;
      line_en_q  <= line_en_d;
      loop_q     <= loop_d;
      cmd_q      <= cmd_d;
      chan_q     <= chan_d;
      thr_q      <= thr_d;
      res_q      <= res_d;
      imp_q      <= imp_d;
      ph_q       <= ph_d;
      dc_pend_q  <= dc_pend_d;
      ac_pend_q  <= ac_pend_d;
      seq_q      <= seq_d;
      cur_q      <= cur_d;
      cnt_q      <= cnt_d;
      gain_q     <= gain_d;
      dc_start_q <= dc_start_d;
      ac_req_q   <= ac_req_d;
    end
  end

  assign dcif.start   = dc_start_q;
  assign dcif.chan    = cur_q;
  assign dcif.thr     = thr_q[cur_q];
  assign dcif.line_en = line_en_q;

  sld_dc_engine u_engine (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .dc         (dcif),
    .meas_done  (meas_done),
    .meas_flag  (meas_flag),
    .meas_value (meas_value),
    .meas_req   (meas_req),
    .meas_kind  (meas_kind),
    .meas_chan  (meas_chan)
  );

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign ac_req                 = ac_req_q;
  assign ac_chan                = cur_q;
  assign ac_loopback_select     = loop_q;
  assign tone_gain              = gain_q;
  assign chan_state             = chan_q;
  assign pair12_parallel_select = pair_q[1];
  assign pair34_parallel_select = pair_q[0];

endmodule : sld_diag_top

// [logic/sld_pkg.sv]
/*
  Constants and helpers for load diagnostics.
  Assumes 32-bit APB and a 10 MHz pclk.
*/
// Operation
// (R1) DC diagnostics on after reset; a control bit bypasses them.
// (R2) Leaving high impedance for mute or play runs DC diagnostics.
// (R3) Software may start DC diagnostics on any channels; others keep playing.
// (R4) A playing channel ramps down to high impedance before testing.
// (R5) DC diagnostics need only valid supplies, no audio clocks.
// (R6) DC results are stored per channel in readable status.
// (R7) DC tests: short to supply, short to ground, open load, shorted load.
// (R8) Each channel has its own shorted-load threshold and compare.
// (R9) After open load, line-output check runs only if its enable is set.
// (R10) Host mutes any external amplifier before the line-output check.
// (R11) Host sets channels high impedance and clears loopback before AC test.
// (R12) Host supplies full-scale tone, 10-20 kHz, one channel at a time.
// (R13) AC test tone ramps up and down automatically.
// (R14) Setting AC enable bits 3:0 starts impedance and phase measurement.
// (R15) AC impedance results read back at indices 0x17 to 0x1A.
// (R16) AC test completion returns channel to high impedance, shown in status.
// (R17) Loopback select bit switches AC test to loopback delay mode.
// (R18) In loopback, bit 3 drives channel 1 loop, bit 1 channel 3 loop.
// (R19) Loopback phase result read back at indices 0x1B and 0x1C.
// (R20) Host clears paired-bridge bits 5:4 for loopback, then restores them.
// (R21) AC request on a channel not in high impedance is ignored.
package sld_pkg;

  localparam int CHANNELS = 4;
  localparam int ADDR_W   = 10;
  localparam int DATA_W   = 32;
  localparam int MEAS_W   = 16;
  localparam int THR_W    = 8;
  localparam int GAIN_W   = 8;
  localparam int CNT_W    = 16;
  localparam int RES_W    = 5;

  // Register indices; byte address = 4 * index
  localparam logic [7:0] IDX_PAIR      = 8'h00;
  localparam logic [7:0] IDX_CHAN_CMD  = 8'h04;
  localparam logic [7:0] IDX_DC_CTRL   = 8'h08;
  localparam logic [7:0] IDX_SL_THR    = 8'h09;
  localparam logic [7:0] IDX_DC_STAT   = 8'h0A;
  localparam logic [7:0] IDX_CHAN_STAT = 8'h0B;
  localparam logic [7:0] IDX_AC_EN     = 8'h15;
  localparam logic [7:0] IDX_AC_CFG    = 8'h16;
  localparam logic [7:0] IDX_AC_IMP0   = 8'h17;
  localparam logic [7:0] IDX_AC_IMP3   = 8'h1A;
  localparam logic [7:0] IDX_AC_PH0    = 8'h1B;
  localparam logic [7:0] IDX_AC_PH1    = 8'h1C;

  // Field positions
  localparam int PAIR12_BIT    = 5;
  localparam int PAIR34_BIT    = 4;
  localparam int DC_BYPASS_BIT = 0;
  localparam int LINE_DET_BIT  = 1;
  localparam int DC_MAN_LSB    = 4;
  localparam int LOOPBACK_BIT  = 7;
  localparam int SUPPLY_OK_BIT = 12;
  localparam int RES_S2P  = 0;
  localparam int RES_S2G  = 1;
  localparam int RES_OL   = 2;
  localparam int RES_SL   = 3;
  localparam int RES_LINE = 4;

  // Reset values
  localparam logic [THR_W-1:0] SL_THR_RST = 8'h10;
  localparam logic [1:0]       CMD_RST    = 2'h0;

  // Channel states
  localparam logic [2:0] CH_HIZ  = 3'h0;
  localparam logic [2:0] CH_MUTE = 3'h1;
  localparam logic [2:0] CH_PLAY = 3'h2;
  localparam logic [2:0] CH_RAMP = 3'h3;
  localparam logic [2:0] CH_DC   = 3'h4;
  localparam logic [2:0] CH_AC   = 3'h5;

  // Commanded state codes
  localparam logic [1:0] CMD_MUTE = 2'h1;
  localparam logic [1:0] CMD_PLAY = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int AUDIO_RAMP_NS  = 10000;
  localparam int TONE_STEP_NS   = 1000;
  localparam logic [CNT_W-1:0] AUDIO_RAMP_CYC =
    CNT_W'((AUDIO_RAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TONE_STEP_CYC =
    CNT_W'((TONE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [GAIN_W-1:0] GAIN_MAX = 8'hFF;

  typedef enum logic [2:0] {
    T_S2P, T_S2G, T_OL, T_SL, T_LINE
  } sld_test_t;

  typedef enum logic [2:0] {
    SQ_IDLE, SQ_RAMP, SQ_DC, SQ_AC_UP, SQ_AC_MEAS, SQ_AC_DOWN
  } sld_seq_t;

  typedef enum logic [1:0] {
    EN_IDLE, EN_REQ, EN_WAIT, EN_DONE
  } sld_eng_t;

  // Channel to AC enable bit: channel 1 sits at bit 3
  function automatic int ac_bit(input int ch);
    return CHANNELS - 1 - ch;
  endfunction : ac_bit

  // Lowest set channel of a mask
  function automatic logic [1:0] lowest_ch(input logic [CHANNELS-1:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : lowest_ch

  function automatic logic [2:0] cmd_state(input logic [1:0] cmd);
    logic [2:0] r;
    r = CH_HIZ;
    if (cmd == CMD_MUTE) begin
      r = CH_MUTE;
    end else if (cmd == CMD_PLAY) begin
      r = CH_PLAY;
    end
    return r;
  endfunction : cmd_state

endpackage : sld_pkg

// [tb/sld_afe_model.sv]
/* Front end stand-in answering DC and AC measurement requests.
   Assumes single-cycle request pulses on pclk. */
module sld_afe_model (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               meas_req,
  input  wire sld_pkg::sld_test_t meas_kind,
  input  wire logic               ac_req,
  input  wire logic [1:0]         ac_chan,
  input  wire logic [4:0]         flags,
  input  wire logic [15:0]        slv,
  input  wire logic [15:0]        acv,
  input  wire logic               slow,
  output logic                    meas_done,
  output logic                    meas_flag,
  output logic [15:0]             meas_value,
  output logic                    ac_done,
  output logic [15:0]             ac_value
);
  import sld_pkg::*;
  logic [3:0] dc_q, ac_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {dc_q, ac_q, meas_done, meas_flag, meas_value, ac_done,
       ac_value} <= '0;
    end else begin
      dc_q <= meas_req ? (slow ? 4'h7 : 4'h1) : dc_q - {3'h0, |dc_q};
      ac_q <= ac_req ? (slow ? 4'h7 : 4'h1) : ac_q - {3'h0, |ac_q};
      meas_done <= dc_q == 4'h1;
      // Flag and value lines toggle when not answering
      meas_flag <= (dc_q == 4'h1) ? flags[meas_kind] : ~meas_flag;
      meas_value <= (dc_q == 4'h1) ? slv : ~meas_value;
      ac_done <= ac_q == 4'h1;
      ac_value <= (ac_q == 4'h1) ? acv ^ {14'h0, ac_chan} : ~ac_value;
    end
  end
endmodule : sld_afe_model

// [tb/sld_diag_asserts.sv]
/* Port timing checks for sld_diag_top.
   Assumes clk_en is held high. */
module sld_diag_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        supply_ok,
  input wire logic        meas_req,
  input wire logic        ac_req,
  input wire logic [7:0]  tone_gain,
  input wire logic [11:0] chan_state
);
  import sld_pkg::*;
  logic [2:0] c1;
  assign c1 = chan_state[2:0];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && $rose(penable);
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  a_ready_wait: assert property (s_setup |-> s_answer)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  a_dc_supply: assert property (c1 == CH_DC && $past(c1) != CH_DC
    |-> $past(supply_ok)) else $error("dc without supply");
  a_ramp_first: assert property ($past(c1) == CH_PLAY |-> c1 != CH_DC)
    else $error("dc straight from play");
  a_ac_from_hiz: assert property (c1 == CH_AC && $past(c1) != CH_AC
    |-> $past(c1) == CH_HIZ) else $error("ac not from hiz");
  a_ac_end_hiz: assert property ($past(c1) == CH_AC && c1 != CH_AC
    |-> c1 == CH_HIZ) else $error("ac end not hiz");
  a_gain_full: assert property (ac_req |-> tone_gain == GAIN_MAX)
    else $error("ac_req before full gain");
  a_gain_step: assert property ($changed(tone_gain) |->
    tone_gain - $past(tone_gain) == 8'h01 ||
    $past(tone_gain) - tone_gain == 8'h01) else $error("gain jump");
  a_meas_pulse: assert property (meas_req |=> !meas_req)
    else $error("meas_req held");
endmodule : sld_diag_asserts

bind sld_diag_top sld_diag_asserts chk_u (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .supply_ok, .meas_req, .ac_req,
  .tone_gain, .chan_state);

// [tb/tb_top.sv]
/* Self-checking bench for sld_diag_top over APB.
   Assumes sld_afe_model as the front end. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sld_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, supply_ok, slow, le;
  logic pready, meas_req, meas_done, meas_flag, ac_req, ac_done;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, thr;
  logic [15:0] meas_value, ac_value, slv, acv;
  logic [11:0] chan_state;
  logic [7:0]  tone_gain;
  logic [4:0]  flags;
  logic [1:0]  ac_chan;
  sld_test_t   meas_kind;
  logic [31:0] expq[$];
  logic [4:0]  res[4];
  logic [2:0]  es[4];
  int          num_errors, comparisons, cyc;

  sld_diag_top dut_u (.pclk, .presetn, .clk_en(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(), .supply_ok,
    .meas_req, .meas_kind, .meas_chan(), .meas_done, .meas_flag,
    .meas_value, .ac_req, .ac_chan, .ac_loopback_select(), .ac_done,
    .ac_value, .tone_gain, .chan_state, .pair12_parallel_select(),
    .pair34_parallel_select());
  sld_afe_model afe_u (.pclk, .presetn, .meas_req, .meas_kind, .ac_req,
    .ac_chan, .flags, .slv, .acv, .slow, .meas_done, .meas_flag,
    .meas_value, .ac_done, .ac_value);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pready && !pwrite) begin
      chk(prdata, expq.pop_front());
    end
    if (cyc == 80000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    expq.push_back(e);
    apb(1'b0, i, 32'h0000_0000);
  endtask : rd

  // Eight quiet cycles in a row
  task automatic settle;
    for (int n = 0; n < 8; n++) begin
      @(posedge pclk);
      foreach (es[i]) if (chan_state[3*i+:3] >= CH_RAMP) n = -1;
    end
  endtask : settle

  task automatic stat;
    rd(IDX_CHAN_STAT, {19'h0, supply_ok, es[3], es[2], es[1], es[0]});
  endtask : stat

  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn, slow, le} = '0;
    {flags, slv, acv, cyc, num_errors, comparisons} = '0;
    supply_ok = 1'b1;
    foreach (es[i]) es[i] = CH_HIZ;
    foreach (res[i]) res[i] = 5'h00;
    void'($urandom(30039));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_SL_THR, 32'h1010_1010);
    rd(IDX_DC_CTRL, 32'h0000_0000);
    rd(8'h3F, 32'h0000_0000);
    stat();
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      thr = $urandom;
      slv = {8'h00, 8'($urandom)};
      flags = 5'($urandom);
      if (c >= 2) flags[2] = 1'b1;
      le = (c == 3) ? 1'b1 : 1'($urandom);
      slow = c[0];
      // No external amp to mute
      apb(1'b1, IDX_DC_CTRL, {30'h0, le, 1'b0});
      apb(1'b1, IDX_SL_THR, thr);
      apb(1'b1, IDX_CHAN_CMD, 32'h0000_0001 << (2 * c));
      settle();
      res[c] = {flags[4] & flags[2] & le, slv < thr[8*c+:8], flags[2:0]};
      foreach (es[i]) es[i] = CH_HIZ;
      es[c] = (|res[c][3:0]) ? CH_HIZ : CH_MUTE;
      rd(IDX_DC_STAT, {3'h0, res[3], 3'h0, res[2], 3'h0, res[1],
                       3'h0, res[0]});
      stat();
    end
    $display("test dc sequence done");
    apb(1'b1, IDX_DC_CTRL, 32'h0000_0001);
    {flags, slv} = {5'h00, 16'hFFFF};
    apb(1'b1, IDX_CHAN_CMD, 32'h0000_000A);
    es = '{CH_PLAY, CH_PLAY, CH_HIZ, CH_HIZ};
    stat();
    apb(1'b1, IDX_DC_CTRL, 32'h0000_0010);
    es[0] = CH_RAMP;
    stat();
    settle();
    es[0] = CH_PLAY;
    stat();
    supply_ok <= 1'b0;
    apb(1'b1, IDX_CHAN_CMD, 32'h0000_001A);
    stat();
    supply_ok <= 1'b1;
    settle();
    es[2] = CH_MUTE;
    stat();
    $display("test manual dc done");
    acv = 16'($urandom);
    apb(1'b1, IDX_AC_CFG, 32'h0000_0000);
    apb(1'b1, IDX_AC_EN, 32'h0000_0009);
    settle();
    rd(IDX_AC_IMP3, {16'h0000, acv ^ 16'h0003});
    rd(IDX_AC_IMP0, 32'h0000_0000);
    stat();
    rd(IDX_AC_EN, 32'h0000_0000);
    $display("test ac impedance done");
    slow = 1'b1;
    apb(1'b1, IDX_CHAN_CMD, 32'h0000_0000);
    apb(1'b1, IDX_PAIR, 32'h0000_0000);
    apb(1'b1, IDX_AC_CFG, 32'h0000_0080);
    apb(1'b1, IDX_AC_EN, 32'h0000_000E);
    settle();
    rd(IDX_AC_PH0, {16'h0000, acv});
    rd(IDX_AC_PH1, {16'h0000, acv ^ 16'h0002});
    rd(IDX_AC_IMP0 + 8'h01, 32'h0000_0000);
    apb(1'b1, IDX_PAIR, 32'h0000_0030);
    rd(IDX_PAIR, 32'h0000_0030);
    $display("test loopback done");
    end_sim();
  end
endmodule : tb_top
